//--- logic/rcia_defs.vh
// Constants for the radio core interrupt aggregator: register offsets,
// bit positions, reset values and writable-bit masks.
// Assumes inclusion by bare name from the design files under logic/ and the checker and bench under verif/.
`ifndef RCIA_DEFS_VH
`define RCIA_DEFS_VH

// ==========================================================================
// Register offsets (16-bit register port address).
`define RCIA_ADDR_W 16
`define RCIA_OFF_EVENT_FLAGS_B 16'h0091
`define RCIA_OFF_ERROR_FLAGS 16'h00bf
`define RCIA_OFF_EVENT_FLAGS_A 16'h00e9
`define RCIA_OFF_EVENT_MASK_A 16'h61a3
`define RCIA_OFF_EVENT_MASK_B 16'h61a4
`define RCIA_OFF_ERROR_MASK 16'h61a5
`define RCIA_OFF_CPU_CTRL 16'h61a6

// ==========================================================================
// Reset values and implemented-bit masks.
`define RCIA_RESET_BYTE 8'h00
`define RCIA_BITS_A 8'hfe
`define RCIA_BITS_B 8'h3f
`define RCIA_BITS_ERR 8'h7f
`define RCIA_MASK_A_BITS 8'hff

// ==========================================================================
// CPU control register fields.
`define RCIA_CPU_ERR_EN 0
`define RCIA_CPU_NRM_EN 1
`define RCIA_CPU_ERR_FLAG 2
`define RCIA_CPU_NRM_FLAG 3

// ==========================================================================
// Bit positions of the individual sources.
`define RCIA_A_RXEN_CLR 7
`define RCIA_A_RX_DONE 6
`define RCIA_A_FILTER_OK 5
`define RCIA_A_SRC_HIT 4
`define RCIA_A_SRC_DONE 3
`define RCIA_A_RX_THRESH 2
`define RCIA_A_SFD 1
`define RCIA_B_RESUMED 5
`define RCIA_B_HALTED 4
`define RCIA_B_MANUAL 3
`define RCIA_B_IDLE 2
`define RCIA_B_TX_DONE 1
`define RCIA_B_ACK_SENT 0
`define RCIA_E_CMD_REJ 6
`define RCIA_E_TX_UNDER 5
`define RCIA_E_TX_OVER 4
`define RCIA_E_RX_UNDER 3
`define RCIA_E_RX_OVER 2
`define RCIA_E_RX_ABORT 1
`define RCIA_E_SYNTH 0

`endif

//--- logic/rcia_top.v
// Radio core interrupt aggregator: event flags, masks, combined requests
// and the CPU-level vector flags with their enables.
// Assumes single-cycle event pulses from the radio, synchronous to clk,
// and a register port master that never needs wait states; the CPU side
// sees two level requests held until software clears them.
//
// Function
// - Drive error request (vector 0) and normal request (vector 12).
// - Normal request combines normal flags and fires on a rising edge.
// - Each source has its own flag bit and its own mask bit.
// - Flags update on events regardless of the mask state.
// - Clearing one flag with other unmasked flags set raises another request.
// - Vector enable and CPU-level flag must both be set to reach CPU.
// - CPU-level error and normal flags set when combined request fires.
// - Flags A bits 7,6,5: receive enable cleared, frame received, filter pass.
// - Flags A bit 4 source match hit, bit 3 source match finished.
// - Flags A bit 2 on threshold exceeded and on complete frame.
// - Flags A bit 1 on start-of-frame delimiter; bit 0 reserved.
// - Flags B bits 5,4,3: resumed, halted, manual; bits 7:6 zero.
// - Flags B bits 2,1,0: idle entered, frame sent, acknowledgement sent.
// - Error bit 6 on rejected command strobe.
// - Error bits 5..2 on FIFO under/overflows; bit 7 zero.
// - Error bit 1 on reception abort, bit 0 on synthesizer lock failure.
// - Event masks mirror flag positions, 1 enables, reset to 0.
// - Error mask mirrors error flag positions, 1 enables.
`timescale 1ns/10ps
`default_nettype none
`include "rcia_defs.vh"

module rcia_top (
  // Clock and reset.
  input wire clk,
  input wire reset_n,
  // Register port.
  input wire [`RCIA_ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata_ff,
  // Normal event pulses from the radio.
  input wire receive_enable_cleared,
  input wire rx_frame_complete,
  input wire frame_passed_filter,
  input wire source_match_hit,
  input wire source_match_finished,
  input wire rx_threshold_reached,
  input wire sfd_seen,
  input wire strobe_processor_resumed,
  input wire strobe_processor_halted,
  input wire strobe_processor_manual_irq,
  input wire radio_entered_idle,
  input wire tx_frame_complete,
  input wire ack_frame_sent,
  // Error event pulses from the radio.
  input wire command_rejected,
  input wire tx_fifo_underflow,
  input wire tx_fifo_overflow,
  input wire rx_fifo_underflow,
  input wire rx_fifo_overflow,
  input wire reception_aborted,
  input wire synth_lock_failure,
  // CPU interrupt requests.
  output reg radio_error_vector_ff,
  output reg normal_vector_ff
);

  // ========================================================================
  // Register state.
  reg [7:0] radio_event_flags_a_ff;
  reg [7:0] radio_event_flags_b_ff;
  reg [7:0] radio_error_flags_ff;
  reg [7:0] radio_event_mask_a_ff;
  reg [7:0] radio_event_mask_b_ff;
  reg [7:0] radio_error_mask_ff;
  reg error_vector_enable_ff;
  reg normal_vector_enable_ff;
  reg error_vector_cpu_flag_ff;
  reg normal_vector_cpu_flag_ff;
  reg err_req_ff;
  reg nrm_req_ff;

  // Next-state values and event vectors, all combinational.
  reg [7:0] nxt_flags_a;
  reg [7:0] nxt_flags_b;
  reg [7:0] nxt_err_flags;
  reg [7:0] ev_a;
  reg [7:0] ev_b;
  reg [7:0] ev_err;
  reg [7:0] nxt_rdata;
  reg nxt_err_cpu;
  reg nxt_nrm_cpu;

  // Decoded strobes and request terms.
  wire wr_a;
  wire wr_b;
  wire wr_e;
  wire wr_mask_a;
  wire wr_mask_b;
  wire wr_mask_e;
  wire wr_ctrl;
  wire err_req;
  wire nrm_req;
  wire nrm_clears;
  wire err_clears;
  wire nrm_req_post;
  wire err_req_post;
  wire nrm_retrigger;
  wire err_retrigger;
  wire nrm_rise;
  wire err_rise;

  // ========================================================================
  // Event vectors gathered at their flag positions.
  always @* begin
    ev_a = `RCIA_RESET_BYTE;
    ev_b = `RCIA_RESET_BYTE;
    ev_err = `RCIA_RESET_BYTE;
    ev_a[`RCIA_A_RXEN_CLR] = receive_enable_cleared;
    ev_a[`RCIA_A_RX_DONE] = rx_frame_complete;
    ev_a[`RCIA_A_FILTER_OK] = frame_passed_filter;
    ev_a[`RCIA_A_SRC_HIT] = source_match_hit;
    ev_a[`RCIA_A_SRC_DONE] = source_match_finished;
    // A complete frame also raises the threshold flag.
    ev_a[`RCIA_A_RX_THRESH] = rx_threshold_reached | rx_frame_complete;
    ev_a[`RCIA_A_SFD] = sfd_seen;
    // Bit 0 of flags A has no source, so it can never be set.
    ev_b[`RCIA_B_RESUMED] = strobe_processor_resumed;
    ev_b[`RCIA_B_HALTED] = strobe_processor_halted;
    ev_b[`RCIA_B_MANUAL] = strobe_processor_manual_irq;
    ev_b[`RCIA_B_IDLE] = radio_entered_idle;
    ev_b[`RCIA_B_TX_DONE] = tx_frame_complete;
    ev_b[`RCIA_B_ACK_SENT] = ack_frame_sent;
    ev_err[`RCIA_E_CMD_REJ] = command_rejected;
    ev_err[`RCIA_E_TX_UNDER] = tx_fifo_underflow;
    ev_err[`RCIA_E_TX_OVER] = tx_fifo_overflow;
    ev_err[`RCIA_E_RX_UNDER] = rx_fifo_underflow;
    ev_err[`RCIA_E_RX_OVER] = rx_fifo_overflow;
    ev_err[`RCIA_E_RX_ABORT] = reception_aborted;
    ev_err[`RCIA_E_SYNTH] = synth_lock_failure;
  end

  // ========================================================================
  // Write decode.
  assign wr_a = reg_wr && (reg_addr == `RCIA_OFF_EVENT_FLAGS_A);
  assign wr_b = reg_wr && (reg_addr == `RCIA_OFF_EVENT_FLAGS_B);
  assign wr_e = reg_wr && (reg_addr == `RCIA_OFF_ERROR_FLAGS);
  // Mask registers and the control enables are written whole; reserved bits drop below.
  assign wr_mask_a = reg_wr && (reg_addr == `RCIA_OFF_EVENT_MASK_A);
  assign wr_mask_b = reg_wr && (reg_addr == `RCIA_OFF_EVENT_MASK_B);
  assign wr_mask_e = reg_wr && (reg_addr == `RCIA_OFF_ERROR_MASK);
  assign wr_ctrl = reg_wr && (reg_addr == `RCIA_OFF_CPU_CTRL);

  // ========================================================================
  // Flag update: a write of 0 clears, an event in the same cycle wins, and
  // unimplemented bits stay zero. Masks are not consulted here on purpose.
  // Reserved positions are cut after the merge, so no event path sets them.
  always @* begin
    nxt_flags_a = radio_event_flags_a_ff;
    nxt_flags_b = radio_event_flags_b_ff;
    nxt_err_flags = radio_error_flags_ff;
    if (wr_a) begin
      nxt_flags_a = nxt_flags_a & reg_wdata;
    end
    if (wr_b) begin
      nxt_flags_b = nxt_flags_b & reg_wdata;
    end
    if (wr_e) begin
      nxt_err_flags = nxt_err_flags & reg_wdata;
    end
    nxt_flags_a = (nxt_flags_a | ev_a) & `RCIA_BITS_A;
    nxt_flags_b = (nxt_flags_b | ev_b) & `RCIA_BITS_B;
    nxt_err_flags = (nxt_err_flags | ev_err) & `RCIA_BITS_ERR;
  end

  // ========================================================================
  // Combined requests: OR over sources of flag AND mask.
  // These are levels; the edge detection below turns a rise into one
  // trigger for the CPU-level flag.
  assign nrm_req = |(radio_event_flags_a_ff & radio_event_mask_a_ff) |
                   |(radio_event_flags_b_ff & radio_event_mask_b_ff);
  assign err_req = |(radio_error_flags_ff & radio_error_mask_ff);

  // ========================================================================
  // Retrigger on a partial clear. Clearing one core flag while other
  // unmasked flags stay set keeps the combined request high, so no edge
  // appears; such a write counts as a fresh trigger instead. The request is
  // judged after the write, so clearing the last flag raises nothing.
  assign nrm_clears = (wr_a && |(radio_event_flags_a_ff & ~reg_wdata)) ||
                      (wr_b && |(radio_event_flags_b_ff & ~reg_wdata));
  assign err_clears = wr_e && |(radio_error_flags_ff & ~reg_wdata);
  assign nrm_req_post = |(nxt_flags_a & radio_event_mask_a_ff) |
                        |(nxt_flags_b & radio_event_mask_b_ff);
  assign err_req_post = |(nxt_err_flags & radio_error_mask_ff);
  assign nrm_retrigger = nrm_clears && nrm_req_post;
  assign err_retrigger = err_clears && err_req_post;

  // ========================================================================
  // Rising edges of the combined requests.
  assign nrm_rise = nrm_req && !nrm_req_ff;
  assign err_rise = err_req && !err_req_ff;

  // ========================================================================
  // CPU-level flags: a write of 0 clears, a trigger in the same cycle wins.
  always @* begin
    nxt_err_cpu = error_vector_cpu_flag_ff;
    nxt_nrm_cpu = normal_vector_cpu_flag_ff;
    if (wr_ctrl && !reg_wdata[`RCIA_CPU_ERR_FLAG]) begin
      nxt_err_cpu = 1'b0;
    end
    if (wr_ctrl && !reg_wdata[`RCIA_CPU_NRM_FLAG]) begin
      nxt_nrm_cpu = 1'b0;
    end
    if (err_rise || err_retrigger) begin
      nxt_err_cpu = 1'b1;
    end
    if (nrm_rise || nrm_retrigger) begin
      nxt_nrm_cpu = 1'b1;
    end
  end

  // ========================================================================
  // Read mux; unmapped addresses read zero.
  always @* begin
    nxt_rdata = `RCIA_RESET_BYTE;
    if (reg_addr == `RCIA_OFF_EVENT_FLAGS_A) begin
      nxt_rdata = radio_event_flags_a_ff;
    end else if (reg_addr == `RCIA_OFF_EVENT_FLAGS_B) begin
      nxt_rdata = radio_event_flags_b_ff;
    end else if (reg_addr == `RCIA_OFF_ERROR_FLAGS) begin
      nxt_rdata = radio_error_flags_ff;
    end else if (reg_addr == `RCIA_OFF_EVENT_MASK_A) begin
      nxt_rdata = radio_event_mask_a_ff;
    end else if (reg_addr == `RCIA_OFF_EVENT_MASK_B) begin
      nxt_rdata = radio_event_mask_b_ff;
    end else if (reg_addr == `RCIA_OFF_ERROR_MASK) begin
      nxt_rdata = radio_error_mask_ff;
    end else if (reg_addr == `RCIA_OFF_CPU_CTRL) begin
      // Enables in the low bits, CPU-level flags above them.
      nxt_rdata[`RCIA_CPU_ERR_EN] = error_vector_enable_ff;
      nxt_rdata[`RCIA_CPU_NRM_EN] = normal_vector_enable_ff;
      nxt_rdata[`RCIA_CPU_ERR_FLAG] = error_vector_cpu_flag_ff;
      nxt_rdata[`RCIA_CPU_NRM_FLAG] = normal_vector_cpu_flag_ff;
    end
    // Outside a read the data return to zero, so a stale value never
    // looks like a fresh answer.
    if (!reg_rd) begin
      nxt_rdata = `RCIA_RESET_BYTE;
    end
  end

  // ========================================================================
  // Core flag registers. Events land here whatever the masks say; only a
  // software write of 0 clears a bit.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      radio_event_flags_a_ff <= `RCIA_RESET_BYTE;
      radio_event_flags_b_ff <= `RCIA_RESET_BYTE;
      radio_error_flags_ff <= `RCIA_RESET_BYTE;
    end else begin
      radio_event_flags_a_ff <= nxt_flags_a;
      radio_event_flags_b_ff <= nxt_flags_b;
      radio_error_flags_ff <= nxt_err_flags;
    end
  end

  // ========================================================================
  // Source masks. Only implemented positions are stored, so reserved mask
  // bits read back as zero; bit 0 of mask A is kept though it has no source.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      radio_event_mask_a_ff <= `RCIA_RESET_BYTE;
      radio_event_mask_b_ff <= `RCIA_RESET_BYTE;
      radio_error_mask_ff <= `RCIA_RESET_BYTE;
    end else begin
      if (wr_mask_a) begin
        radio_event_mask_a_ff <= reg_wdata & `RCIA_MASK_A_BITS;
      end
      if (wr_mask_b) begin
        radio_event_mask_b_ff <= reg_wdata & `RCIA_BITS_B;
      end
      if (wr_mask_e) begin
        radio_error_mask_ff <= reg_wdata & `RCIA_BITS_ERR;
      end
    end
  end

  // ========================================================================
  // Vector enables. They gate only the requests to the CPU; the CPU-level
  // flags keep recording edges while a vector is disabled.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      error_vector_enable_ff <= 1'b0;
      normal_vector_enable_ff <= 1'b0;
    end else if (wr_ctrl) begin
      error_vector_enable_ff <= reg_wdata[`RCIA_CPU_ERR_EN];
      normal_vector_enable_ff <= reg_wdata[`RCIA_CPU_NRM_EN];
    end
  end

  // ========================================================================
  // CPU-level flags and the request history used for edge detection. The
  // history resets low, matching an idle request, so no false edge follows
  // reset.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      error_vector_cpu_flag_ff <= 1'b0;
      normal_vector_cpu_flag_ff <= 1'b0;
      err_req_ff <= 1'b0;
      nrm_req_ff <= 1'b0;
    end else begin
      error_vector_cpu_flag_ff <= nxt_err_cpu;
      normal_vector_cpu_flag_ff <= nxt_nrm_cpu;
      err_req_ff <= err_req;
      nrm_req_ff <= nrm_req;
    end
  end

  // ========================================================================
  // Read data register. It stands for one cycle after the read strobe and
  // is zero otherwise, so a master may sample it without a valid flag.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata_ff <= `RCIA_RESET_BYTE;
    end else begin
      reg_rdata_ff <= nxt_rdata;
    end
  end

  // ========================================================================
  // Requests to the CPU. Both the vector enable and the CPU-level flag must
  // be set; the enable is the registered one, so a change of enable reaches
  // the pin one cycle after the write.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      radio_error_vector_ff <= 1'b0;
      normal_vector_ff <= 1'b0;
    end else begin
      radio_error_vector_ff <= nxt_err_cpu & error_vector_enable_ff;
      normal_vector_ff <= nxt_nrm_cpu & normal_vector_enable_ff;
    end
  end

endmodule // rcia_top
`default_nettype wire

//--- verif/rcia_top_assertions.sv
// Port checker for the radio core interrupt aggregator.
// Assumes a bind to rcia_top on one clock.
`timescale 1ns/10ps
`default_nettype none
`include "rcia_defs.vh"

// ==================================================
// Checker
module rcia_top_checker (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Register port.
  input wire logic [`RCIA_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata_ff,
  // CPU requests.
  input wire logic radio_error_vector_ff,
  input wire logic normal_vector_ff
);
  logic [15:0] ra_ff;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Address of the last read, all ones when none; no register lives there.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ra_ff <= 16'hffff;
    end else begin
      ra_ff <= reg_rd ? reg_addr : 16'hffff;
    end
  end
  chk_idle_data_zero: assert property (ra_ff == 16'hffff |-> reg_rdata_ff == 8'h00)
    else $error("read data outside a read");
  chk_flagb_reserved: assert property (ra_ff == `RCIA_OFF_EVENT_FLAGS_B |->
    reg_rdata_ff[7:6] == 2'h0) else $error("flags b reserved bits set");
  chk_error_reserved: assert property (ra_ff == `RCIA_OFF_ERROR_FLAGS |->
    !reg_rdata_ff[7]) else $error("error flag bit 7 set");
  chk_flaga_reserved: assert property (ra_ff == `RCIA_OFF_EVENT_FLAGS_A |->
    !reg_rdata_ff[0]) else $error("flags a bit 0 set");
  chk_maskb_reserved: assert property (ra_ff == `RCIA_OFF_EVENT_MASK_B |->
    reg_rdata_ff[7:6] == 2'h0) else $error("mask b reserved bits set");
  chk_emask_reserved: assert property (ra_ff == `RCIA_OFF_ERROR_MASK |->
    !reg_rdata_ff[7]) else $error("error mask bit 7 set");
  chk_mask_echo: assert property (reg_wr && reg_addr == `RCIA_OFF_EVENT_MASK_A ##1
    !reg_wr ##1 reg_rd && reg_addr == `RCIA_OFF_EVENT_MASK_A |=>
    reg_rdata_ff == $past(reg_wdata, 3)) else $error("mask a lost its value");
  chk_err_disable: assert property (reg_wr && reg_addr == `RCIA_OFF_CPU_CTRL &&
    !reg_wdata[0] |-> ##[1:2] !radio_error_vector_ff) else $error("error request stuck");
  chk_nrm_disable: assert property (reg_wr && reg_addr == `RCIA_OFF_CPU_CTRL &&
    !reg_wdata[1] |-> ##[1:2] !normal_vector_ff) else $error("normal request stuck");
endmodule // rcia_top_checker

bind rcia_top rcia_top_checker u_chk (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata_ff, .radio_error_vector_ff, .normal_vector_ff);
`default_nettype wire

//--- verif/rcia_cpu_model.sv
// CPU side model: takes each request on its rising edge.
// Assumes level requests synchronous to clk.
`timescale 1ns/10ps
`default_nettype none

// ==================================================
// CPU model
module rcia_cpu_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Requests and the count of each taken.
  input wire logic err_req,
  input wire logic nrm_req,
  output var logic [7:0] err_taken_ff,
  output var logic [7:0] nrm_taken_ff
);
  logic [1:0] last_ff;
  // Vectors are edge triggered, so a held request is taken once.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      last_ff <= 2'h0;
      err_taken_ff <= 8'h00;
      nrm_taken_ff <= 8'h00;
    end else begin
      last_ff <= {err_req, nrm_req};
      err_taken_ff <= err_taken_ff + {7'h00, err_req & !last_ff[1]};
      nrm_taken_ff <= nrm_taken_ff + {7'h00, nrm_req & !last_ff[0]};
    end
  end
endmodule // rcia_cpu_model
`default_nettype wire

//--- verif/tb_radio_core_interrupt_aggregator.sv
// Bench for the interrupt aggregator.
// Assumes rcia_top, its header and rcia_cpu_model.
`timescale 1ns/10ps
`default_nettype none
`include "rcia_defs.vh"

// ==================================================
// Bench
module tb_radio_core_interrupt_aggregator;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [6:0] ea = 7'h00;
  logic [5:0] eb = 6'h00;
  logic [6:0] ee = 7'h00;
  logic [7:0] rdata, ec, nc;
  logic ev, nv;
  logic [15:0] adr [8];
  logic [7:0] kp [8];
  int mismatches = 0;
  int samples_checked = 0;
  always #2 clk = ~clk;
  // Event bits run in flag order, high to low.
  rcia_top dut (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_ff(rdata),
    .receive_enable_cleared(ea[6]), .rx_frame_complete(ea[5]), .frame_passed_filter(ea[4]),
    .source_match_hit(ea[3]), .source_match_finished(ea[2]), .rx_threshold_reached(ea[1]),
    .sfd_seen(ea[0]), .strobe_processor_resumed(eb[5]), .strobe_processor_halted(eb[4]),
    .strobe_processor_manual_irq(eb[3]), .radio_entered_idle(eb[2]),
    .tx_frame_complete(eb[1]), .ack_frame_sent(eb[0]), .command_rejected(ee[6]),
    .tx_fifo_underflow(ee[5]), .tx_fifo_overflow(ee[4]), .rx_fifo_underflow(ee[3]),
    .rx_fifo_overflow(ee[2]), .reception_aborted(ee[1]), .synth_lock_failure(ee[0]),
    .radio_error_vector_ff(ev), .normal_vector_ff(nv));
  rcia_cpu_model cpu (.clk, .reset_n, .err_req(ev), .nrm_req(nv), .err_taken_ff(ec),
    .nrm_taken_ff(nc));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bus tasks start right after an edge; a write leaves one idle cycle.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check(rdata, exp);
    @(posedge clk);
  endtask
  // One-cycle event pulse; two edges on, when a request is due, the requests
  // are compared with exp.
  task automatic pulse(input logic [6:0] a, input logic [5:0] b, input logic [6:0] e,
    input logic [7:0] exp);
    {ea, eb, ee} <= {a, b, e};
    @(posedge clk);
    {ea, eb, ee} <= 20'h00000;
    @(posedge clk);
    #1 check({6'h00, ev, nv}, exp);
    @(posedge clk);
  endtask
  task automatic vec(input logic [7:0] exp);
    #1 check({6'h00, ev, nv}, exp);
    @(posedge clk);
  endtask
  task automatic s_regs();
    adr = '{`RCIA_OFF_EVENT_FLAGS_A, `RCIA_OFF_EVENT_FLAGS_B, `RCIA_OFF_ERROR_FLAGS,
      `RCIA_OFF_EVENT_MASK_A, `RCIA_OFF_EVENT_MASK_B, `RCIA_OFF_ERROR_MASK,
      `RCIA_OFF_CPU_CTRL, 16'h0000};
    kp = '{8'h00, 8'h00, 8'h00, 8'hff, 8'h3f, 8'h7f, 8'h03, 8'h00};
    for (int i = 0; i < 8; i++) begin
      rd(adr[i], 8'h00);
      wr(adr[i], 8'hff);
      rd(adr[i], kp[i]);
      wr(adr[i], 8'h00);
    end
  endtask
  // Masks are all zero here, so flags set but no request follows.
  task automatic s_flags();
    for (int i = 0; i < 7; i++) begin
      pulse(7'h01 << i, (i < 6) ? 6'h01 << i : 6'h00, 7'h01 << i, 8'h00);
      rd(`RCIA_OFF_EVENT_FLAGS_A, (8'h02 << i) | ((i == 5) ? 8'h04 : 8'h00));
      rd(`RCIA_OFF_EVENT_FLAGS_B, (i < 6) ? 8'h01 << i : 8'h00);
      rd(`RCIA_OFF_ERROR_FLAGS, 8'h01 << i);
      wr(`RCIA_OFF_EVENT_FLAGS_A, 8'hff);
      rd(`RCIA_OFF_EVENT_FLAGS_A, (8'h02 << i) | ((i == 5) ? 8'h04 : 8'h00));
      wr(`RCIA_OFF_EVENT_FLAGS_A, 8'h00);
      wr(`RCIA_OFF_EVENT_FLAGS_B, 8'h00);
      wr(`RCIA_OFF_ERROR_FLAGS, 8'h00);
    end
  endtask
  task automatic s_normal();
    wr(`RCIA_OFF_EVENT_MASK_A, 8'h06);
    wr(`RCIA_OFF_CPU_CTRL, 8'h02);
    {ea, eb, ee} <= {7'h01, 13'h0000};
    @(posedge clk);
    {ea, eb, ee} <= 20'h00000;
    @(posedge clk);
    vec(8'h01);
    rd(`RCIA_OFF_CPU_CTRL, 8'h0a);
    pulse(7'h02, 6'h00, 7'h00, 8'h01);
    wr(`RCIA_OFF_CPU_CTRL, 8'h02);
    vec(8'h00);
    wr(`RCIA_OFF_EVENT_FLAGS_A, 8'hfb);
    rd(`RCIA_OFF_CPU_CTRL, 8'h0a);
    wr(`RCIA_OFF_CPU_CTRL, 8'h02);
    wr(`RCIA_OFF_EVENT_FLAGS_A, 8'h00);
    rd(`RCIA_OFF_CPU_CTRL, 8'h02);
    check(nc, 8'h02);
  endtask
  task automatic s_error();
    wr(`RCIA_OFF_ERROR_MASK, 8'h01);
    wr(`RCIA_OFF_CPU_CTRL, 8'h01);
    ee <= 7'h01;
    @(posedge clk);
    ee <= 7'h00;
    @(posedge clk);
    vec(8'h02);
    wr(`RCIA_OFF_CPU_CTRL, 8'h04);
    vec(8'h00);
    wr(`RCIA_OFF_CPU_CTRL, 8'h05);
    vec(8'h02);
    wr(`RCIA_OFF_ERROR_FLAGS, 8'h00);
    wr(`RCIA_OFF_CPU_CTRL, 8'h01);
    vec(8'h00);
    check(ec, 8'h02);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #20000;
    mismatches++;
    complete_run();
  end
  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    s_regs();
    s_flags();
    s_normal();
    s_error();
    complete_run();
  end
endmodule // tb_radio_core_interrupt_aggregator
`default_nettype wire
